// [pcp_port.sv]
// parallel lcd transmit, camera capture and converter streaming port
// assumes register strobes and dma events come from clk_sys_i logic
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
//Contract
// - word select runs at half bit clock
// - converter mode times from halved pll clock
// - lcd drives 24-bit bus, ws strobes
// - lcd mode when enabled, not follower and not converter
// - tx layout fields shape outgoing word
// - two lcd frame forms via doubling bits
// - camera 16-bit bus with three qualifiers
// - camera pixel clock on word select input
// - capture only while all qualifiers high
// - adc uses master receive mode
// - right to first dac, left second
// - converter byte sits in upper byte
// - separate tx and rx stall interrupts
// - six fifo level interrupts
// - descriptor exhaustion interrupts
// - descriptor error interrupts
// - outbound packet end and done interrupts
// - inbound success end and done interrupts
// - raw, masked, enable, clear per source
module pcp_port
	import pcp_pkg::*;
#(
	parameter int DEPTH = 8,
	parameter int STALL_CYCLES = pcp_pkg::PCP_STALL_CYCLES
) (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// camera and converter clock pins
	input wire logic word_select_input_i,
	input wire logic line_sync_in_i,
	input wire logic frame_sync_in_i,
	input wire logic line_valid_in_i,
	input wire logic [15:0] capture_data_in_i,
	input wire logic halved_pll_clock_i,
	// on-chip adc stream
	input wire logic adc_valid_i,
	input wire logic [7:0] adc_data_i,
	// dma descriptor events, one-cycle pulses
	input wire logic [7:0] dma_evt_i,
	// lcd and dac outputs
	output logic bit_clock_o,
	output logic word_select_o,
	output logic [23:0] lcd_data_o,
	output logic [7:0] dac1_o,
	output logic [7:0] dac2_o
);
	import pcp_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = AW'(0) + (AW+1)'(DEPTH);
	localparam logic [AW:0] LOW_CNT = (AW+1)'(1);
	localparam logic [AW:0] HIGH_CNT = (AW+1)'(DEPTH - 1);
	localparam logic [15:0] STALL_MAX = 16'(STALL_CYCLES - 1);

	pcp_pin_if pins ();

	// registers
	logic [PCP_CTRL_W-1:0] ctrl_r;
	logic [15:0] layout_r;
	logic [7:0] clkdiv_r;
	logic [15:0] int_ena_r;
	logic [31:0] rdata_r;

	// register decode
	wire sel_ctrl = reg_addr_i == PCP_CTRL_OFS;
	wire sel_layout = reg_addr_i == PCP_LAYOUT_OFS;
	wire sel_clkdiv = reg_addr_i == PCP_CLKDIV_OFS;
	wire sel_txdata = reg_addr_i == PCP_TXDATA_OFS;
	wire sel_rxdata = reg_addr_i == PCP_RXDATA_OFS;
	wire sel_ena = reg_addr_i == PCP_INT_ENA_OFS;
	wire sel_clr = reg_addr_i == PCP_INT_CLR_OFS;

	// control fields
	wire pme = ctrl_r[PCP_B_PME];
	wire cap_en = ctrl_r[PCP_B_CAP_EN];
	wire tx_fol = ctrl_r[PCP_B_TX_FOL];
	wire rx_fol = ctrl_r[PCP_B_RX_FOL];
	wire tx_start = ctrl_r[PCP_B_TX_START];
	wire rx_start = ctrl_r[PCP_B_RX_START];
	wire data_x2 = ctrl_r[PCP_B_DATA_X2];
	wire strb_x2 = ctrl_r[PCP_B_STRB_X2];
	wire conv = ctrl_r[PCP_B_CONV];
	wire adc_route = ctrl_r[PCP_B_ADC_ROUTE];
	wire [2:0] tx_chan = layout_r[PCP_F_TX_CHAN +: 3];
	wire [2:0] tx_fifo_lay = layout_r[PCP_F_TX_FIFO +: 3];
	wire [2:0] rx_fifo_lay = layout_r[PCP_F_RX_FIFO +: 3];

	wire lcd_mode = pme & ~tx_fol & ~conv;
	wire dac_mode = pme & ~tx_fol & conv;
	wire cam_mode = pme & cap_en & rx_fol;
	wire adc_mode = pme & ~rx_fol & conv;
	pcp_tx_mode_t tx_mode;
	assign tx_mode = lcd_mode ? PCP_LCD : (dac_mode ? PCP_DAC : PCP_IDLE);

	pcp_pin_sync u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.word_select_input_i(word_select_input_i),
		.line_sync_in_i(line_sync_in_i),
		.frame_sync_in_i(frame_sync_in_i),
		.line_valid_in_i(line_valid_in_i),
		.halved_pll_clock_i(halved_pll_clock_i),
		.capture_data_in_i(capture_data_in_i),
		.pins(pins)
	);

	// edge detection on synchronised clocks
	logic pclk_d_r, pll_d_r;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pclk_d_r <= 1'b0;
			pll_d_r <= 1'b0;
		end else if (ce_i) begin
			pclk_d_r <= pins.pclk;
			pll_d_r <= pins.pll_clk;
		end
	end
	wire pclk_rise = pins.pclk & ~pclk_d_r;
	wire pll_rise = pins.pll_clk & ~pll_d_r;

	// converter mode ticks on halved pll rising edges
	wire tick = conv ? pll_rise : 1'b1;

	// bit clock divider
	logic [7:0] div_cnt_r;
	logic bck_r, ws_r;
	wire div_hit = tick & (div_cnt_r == clkdiv_r);
	wire bck_rise = div_hit & ~bck_r;
	wire ws_fall = bck_rise & ws_r;
	wire ws_edge = bck_rise;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			div_cnt_r <= 8'h00;
			bck_r <= 1'b0;
			ws_r <= 1'b0;
		end else if (ce_i) begin
			if (!pme) begin
				div_cnt_r <= 8'h00;
				bck_r <= 1'b0;
				ws_r <= 1'b0;
			end else if (tick) begin
				div_cnt_r <= div_hit ? 8'h00 : div_cnt_r + 8'h01;
				bck_r <= bck_r ^ div_hit;
				// ws toggles once per bit clock period
				ws_r <= ws_r ^ bck_rise;
			end
		end
	end

	// transmit fifo, filled by register writes
	logic [31:0] tx_mem [DEPTH];
	logic [AW-1:0] tx_wp_r, tx_rp_r;
	logic [AW:0] tx_cnt_r;
	wire tx_full = tx_cnt_r == FULL_CNT;
	wire tx_empty = tx_cnt_r == '0;
	wire tx_push = reg_wr_i & sel_txdata & ~tx_full;

	// strobe doubling advances per strobe cycle, data doubling repeats
	logic rep_r;
	wire lcd_step = strb_x2 ? ws_fall : ws_edge;
	wire step = (tx_mode == PCP_LCD) ? lcd_step :
		((tx_mode == PCP_DAC) ? ws_fall : 1'b0);
	wire adv = tx_start & step & (~data_x2 | rep_r | (tx_mode == PCP_DAC));
	wire tx_pop = adv & ~tx_empty;
	wire [31:0] tx_word = tx_mem[tx_rp_r];

	always_ff @(posedge clk_sys_i) begin
		if (tx_push & ce_i) begin
			tx_mem[tx_wp_r] <= reg_wdata_i;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			tx_wp_r <= '0;
			tx_rp_r <= '0;
			tx_cnt_r <= '0;
			rep_r <= 1'b0;
		end else if (ce_i) begin
			tx_wp_r <= tx_wp_r + AW'(tx_push);
			tx_rp_r <= tx_rp_r + AW'(tx_pop);
			tx_cnt_r <= tx_cnt_r + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
			if (tx_start & step) begin
				rep_r <= ~rep_r;
			end
		end
	end

	// channel and fifo layouts shape the 24-bit word
	function automatic logic [23:0] lay24(input logic [31:0] w,
		input logic [2:0] chan, input logic [2:0] fl);
		logic [15:0] half;
		half = (chan == 3'h2) ? w[15:0] : w[31:16];
		if (fl == 3'h0) begin
			lay24 = w[23:0];
		end else if (chan == 3'h0) begin
			lay24 = {w[31:24], w[15:0]};
		end else begin
			lay24 = {half, 8'h00};
		end
	endfunction : lay24

	// lcd and dac outputs; last word is held when the fifo runs dry
	logic [23:0] lcd_r;
	logic [7:0] dac1_r, dac2_r;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			lcd_r <= 24'h000000;
			dac1_r <= 8'h00;
			dac2_r <= 8'h00;
		end else if (ce_i & tx_pop) begin
			// full 24-bit bus in lcd mode
			if (tx_mode == PCP_LCD) begin
				lcd_r <= lay24(tx_word, tx_chan, tx_fifo_lay);
			end
			// right to first dac, left to second
			// sample in the upper byte of each element
			if (tx_mode == PCP_DAC) begin
				dac1_r <= tx_word[PCP_SAMPLE_SHIFT +: 8];
				dac2_r <= tx_word[16 + PCP_SAMPLE_SHIFT +: 8];
			end
		end
	end

	// receive side: camera capture or adc stream
	// all three qualifiers high to capture
	wire qual = pins.line_sync_in & pins.frame_sync_in & pins.line_valid_in;
	// 16-bit capture on pixel clock rise
	wire cam_push = cam_mode & rx_start & pclk_rise & qual;
	// adc samples only with route set and receive enabled
	wire adc_push = adc_mode & adc_route & rx_start & adc_valid_i;
	wire [15:0] adc_elem = {adc_data_i, 8'h00};
	wire [15:0] rx_half = cam_push ? pins.capture_data_in : adc_elem;
	// single layout keeps the sample low, dual packs it high
	wire [31:0] rx_word = (rx_fifo_lay == 3'h1) ? {16'h0000, rx_half} :
		{rx_half, 16'h0000};

	logic [31:0] rx_mem [DEPTH];
	logic [AW-1:0] rx_wp_r, rx_rp_r;
	logic [AW:0] rx_cnt_r;
	wire rx_full = rx_cnt_r == FULL_CNT;
	wire rx_empty = rx_cnt_r == '0;
	// a capture that finds the fifo full is dropped
	wire rx_push = (cam_push | adc_push) & ~rx_full;
	wire rx_pop = reg_rd_i & sel_rxdata & ~rx_empty;

	always_ff @(posedge clk_sys_i) begin
		if (rx_push & ce_i) begin
			rx_mem[rx_wp_r] <= rx_word;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rx_wp_r <= '0;
			rx_rp_r <= '0;
			rx_cnt_r <= '0;
		end else if (ce_i) begin
			rx_wp_r <= rx_wp_r + AW'(rx_push);
			rx_rp_r <= rx_rp_r + AW'(rx_pop);
			rx_cnt_r <= rx_cnt_r + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
		end
	end

	// stall timers: started direction with no progress
	logic [15:0] tx_idle_r, rx_idle_r;
	wire tx_wait = tx_start & (tx_mode != PCP_IDLE) & ~tx_pop;
	wire rx_wait = rx_start & (cam_mode | adc_mode) & ~rx_push;
	wire tx_stall = tx_wait & (tx_idle_r == STALL_MAX);
	wire rx_stall = rx_wait & (rx_idle_r == STALL_MAX);
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			tx_idle_r <= 16'h0000;
			rx_idle_r <= 16'h0000;
		end else if (ce_i) begin
			tx_idle_r <= (tx_wait & ~tx_stall) ? tx_idle_r + 16'h0001 : 16'h0000;
			rx_idle_r <= (rx_wait & ~rx_stall) ? rx_idle_r + 16'h0001 : 16'h0000;
		end
	end

	// interrupt sources
	logic [PCP_INT_N-1:0] int_set, int_raw, int_st;
	wire [PCP_INT_N-1:0] int_clr = (reg_wr_i & sel_clr) ?
		reg_wdata_i[PCP_INT_N-1:0] : '0;
	always_comb begin
		int_set = '0;
		int_set[PCP_I_TX_STALL] = tx_stall;
		int_set[PCP_I_RX_STALL] = rx_stall;
		int_set[PCP_I_TX_EMPTY] = tx_empty;
		int_set[PCP_I_TX_FULL] = tx_full;
		int_set[PCP_I_RX_EMPTY] = rx_empty;
		int_set[PCP_I_RX_FULL] = rx_full;
		int_set[PCP_I_TX_LOW] = tx_cnt_r <= LOW_CNT;
		int_set[PCP_I_RX_HIGH] = rx_cnt_r >= HIGH_CNT;
		int_set[PCP_I_DMA +: 8] = dma_evt_i;
	end

	// raw, masked, enable and clear per source
	pcp_irq_bank #(
		.N(PCP_INT_N)
	) u_irq (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.set_i(int_set),
		.clr_i(int_clr),
		.ena_i(int_ena_r),
		.raw_o(int_raw),
		.st_o(int_st)
	);

	// register writes
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctrl_r <= PCP_CTRL_RST;
			layout_r <= PCP_LAYOUT_RST;
			clkdiv_r <= PCP_CLKDIV_RST;
			int_ena_r <= PCP_INT_ENA_RST;
		end else if (ce_i & reg_wr_i) begin
			if (sel_ctrl) begin
				ctrl_r <= reg_wdata_i[PCP_CTRL_W-1:0];
			end else if (sel_layout) begin
				layout_r <= reg_wdata_i[15:0] & 16'h7777;
			end else if (sel_clkdiv) begin
				clkdiv_r <= reg_wdata_i[7:0];
			end else if (sel_ena) begin
				int_ena_r <= reg_wdata_i[PCP_INT_N-1:0];
			end
		end
	end

	// read mux; unmapped and write-only offsets read zero
	wire [31:0] state_word = {12'h000, cam_mode, adc_mode, tx_mode,
		rx_cnt_r[AW:0], {(12-AW-1){1'b0}}, tx_cnt_r[AW:0]};
	logic [31:0] rd_mux;
	always_comb begin
		if (reg_addr_i == PCP_CTRL_OFS) begin
			rd_mux = {22'h000000, ctrl_r};
		end else if (reg_addr_i == PCP_LAYOUT_OFS) begin
			rd_mux = {16'h0000, layout_r};
		end else if (reg_addr_i == PCP_CLKDIV_OFS) begin
			rd_mux = {24'h000000, clkdiv_r};
		end else if (reg_addr_i == PCP_RXDATA_OFS) begin
			rd_mux = rx_empty ? 32'h00000000 : rx_mem[rx_rp_r];
		end else if (reg_addr_i == PCP_INT_RAW_OFS) begin
			rd_mux = {16'h0000, int_raw};
		end else if (reg_addr_i == PCP_INT_ST_OFS) begin
			rd_mux = {16'h0000, int_st};
		end else if (reg_addr_i == PCP_INT_ENA_OFS) begin
			rd_mux = {16'h0000, int_ena_r};
		end else if (reg_addr_i == PCP_STATE_OFS) begin
			rd_mux = state_word;
		end else begin
			rd_mux = 32'h00000000;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rdata_r <= 32'h00000000;
		end else if (ce_i) begin
			rdata_r <= reg_rd_i ? rd_mux : 32'h00000000;
		end
	end

	assign reg_rdata_o = rdata_r;
	assign bit_clock_o = bck_r;
	// word select serves as the panel write strobe
	assign word_select_o = ws_r;
	assign lcd_data_o = lcd_r;
	assign dac1_o = dac1_r;
	assign dac2_o = dac2_r;
endmodule : pcp_port

// [pcp_pkg.sv]
// constants for the parallel lcd / camera / converter port
// assumes a single system clock and a plain register port
package pcp_pkg;
	// register offsets (byte addresses)
	localparam logic [7:0] PCP_CTRL_OFS = 8'h00;
	localparam logic [7:0] PCP_LAYOUT_OFS = 8'h04;
	localparam logic [7:0] PCP_CLKDIV_OFS = 8'h08;
	localparam logic [7:0] PCP_TXDATA_OFS = 8'h0C;
	localparam logic [7:0] PCP_RXDATA_OFS = 8'h10;
	localparam logic [7:0] PCP_INT_RAW_OFS = 8'h14;
	localparam logic [7:0] PCP_INT_ST_OFS = 8'h18;
	localparam logic [7:0] PCP_INT_ENA_OFS = 8'h1C;
	localparam logic [7:0] PCP_INT_CLR_OFS = 8'h20;
	localparam logic [7:0] PCP_STATE_OFS = 8'h24;
	// control bit positions
	localparam int PCP_B_PME = 0;
	localparam int PCP_B_CAP_EN = 1;
	localparam int PCP_B_TX_FOL = 2;
	localparam int PCP_B_RX_FOL = 3;
	localparam int PCP_B_TX_START = 4;
	localparam int PCP_B_RX_START = 5;
	localparam int PCP_B_DATA_X2 = 6;
	localparam int PCP_B_STRB_X2 = 7;
	localparam int PCP_B_CONV = 8;
	localparam int PCP_B_ADC_ROUTE = 9;
	localparam int PCP_CTRL_W = 10;
	// layout field positions
	localparam int PCP_F_TX_CHAN = 0;
	localparam int PCP_F_TX_FIFO = 4;
	localparam int PCP_F_RX_CHAN = 8;
	localparam int PCP_F_RX_FIFO = 12;
	// reset values
	localparam logic [PCP_CTRL_W-1:0] PCP_CTRL_RST = 10'h000;
	localparam logic [15:0] PCP_LAYOUT_RST = 16'h0000;
	localparam logic [7:0] PCP_CLKDIV_RST = 8'h03;
	localparam logic [15:0] PCP_INT_ENA_RST = 16'h0000;
	// interrupt bit positions
	localparam int PCP_I_TX_STALL = 0;
	localparam int PCP_I_RX_STALL = 1;
	localparam int PCP_I_TX_EMPTY = 2;
	localparam int PCP_I_TX_FULL = 3;
	localparam int PCP_I_RX_EMPTY = 4;
	localparam int PCP_I_RX_FULL = 5;
	localparam int PCP_I_TX_LOW = 6;
	localparam int PCP_I_RX_HIGH = 7;
	localparam int PCP_I_DMA = 8;
	localparam int PCP_INT_N = 16;
	// converter sample shift inside a 16-bit element
	localparam int PCP_SAMPLE_SHIFT = 8;
	// stall timeout in cycles
	localparam int PCP_STALL_CYCLES = 1024;
	typedef enum logic [1:0] {
		PCP_IDLE = 2'b00,
		PCP_LCD = 2'b01,
		PCP_DAC = 2'b11
	} pcp_tx_mode_t;
endpackage : pcp_pkg

// [pcp_pin_if.sv]
// synchronised camera and converter-clock pins
// assumes one producer (pin synchroniser) and one consumer
`timescale 1ns/1ps
interface pcp_pin_if;
	logic pclk;
	logic line_sync_in;
	logic frame_sync_in;
	logic line_valid_in;
	logic pll_clk;
	logic [15:0] capture_data_in;
	modport src (output pclk, line_sync_in, frame_sync_in, line_valid_in,
		pll_clk, capture_data_in);
	modport dst (input pclk, line_sync_in, frame_sync_in, line_valid_in,
		pll_clk, capture_data_in);
endinterface : pcp_pin_if

// [pcp_pin_sync.sv]
// three-stage synchroniser for the asynchronous pins
// assumes pins are unrelated to clk_sys_i
`timescale 1ns/1ps
module pcp_pin_sync (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// raw pins
	input wire logic word_select_input_i,
	input wire logic line_sync_in_i,
	input wire logic frame_sync_in_i,
	input wire logic line_valid_in_i,
	input wire logic halved_pll_clock_i,
	input wire logic [15:0] capture_data_in_i,
	// synchronised view
	pcp_pin_if.src pins
);
	logic [20:0] s1_r, s2_r, s3_r, q_r;
	logic [20:0] raw;
	assign raw = {word_select_input_i, line_sync_in_i, frame_sync_in_i,
		line_valid_in_i, halved_pll_clock_i, capture_data_in_i};
	// first stage feeds only the second
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s1_r <= 21'h000000;
			s2_r <= 21'h000000;
			s3_r <= 21'h000000;
		end else if (ce_i) begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	// a bit moves only once two stages agree
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			q_r <= 21'h000000;
		end else if (ce_i) begin
			q_r <= (s2_r & s3_r) | (q_r & (s2_r ^ s3_r));
		end
	end
	assign pins.pclk = q_r[20];
	assign pins.line_sync_in = q_r[19];
	assign pins.frame_sync_in = q_r[18];
	assign pins.line_valid_in = q_r[17];
	assign pins.pll_clk = q_r[16];
	assign pins.capture_data_in = q_r[15:0];
endmodule : pcp_pin_sync

// [pcp_irq_bank.sv]
// sticky raw status, enable mask and write-one clear
// assumes set and clear are one-cycle pulses from clk_sys_i logic
`timescale 1ns/1ps
module pcp_irq_bank #(
	parameter int N = 16
) (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// events and software controls
	input wire logic [N-1:0] set_i,
	input wire logic [N-1:0] clr_i,
	input wire logic [N-1:0] ena_i,
	// status
	output logic [N-1:0] raw_o,
	output logic [N-1:0] st_o
);
	logic [N-1:0] raw_r;
	logic [N-1:0] raw_nxt;
	// sticky until cleared, set beats clear
	assign raw_nxt = (raw_r & ~clr_i) | set_i;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			raw_r <= '0;
		end else if (ce_i) begin
			raw_r <= raw_nxt;
		end
	end
	assign raw_o = raw_r;
	assign st_o = raw_r & ena_i;
endmodule : pcp_irq_bank

// [pcp_port_sva.sv]
// assertions on the register port and word-select output
// assumes binding to pcp_port; strobes count only with ce_i high
`timescale 1ns/1ps
module pcp_port_sva
	import pcp_pkg::*;
#(
	parameter int DEPTH = 8,
	parameter int STALL_CYCLES = 16
) (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	// outputs
	input wire logic bit_clock_o,
	input wire logic word_select_o,
	input wire logic [23:0] lcd_data_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	logic bck_q;
	logic ws_q;
	wire logic rd = reg_rd_i & ce_i;
	wire logic wr = reg_wr_i & ce_i;
	wire logic rose = bit_clock_o & ~bck_q;
	wire logic ws_chg = word_select_o != ws_q;
	wire logic ctl_wr = wr && reg_addr_i == PCP_CTRL_OFS;
	wire logic [15:0] clr;
	logic [9:0] ctrl_r;
	logic [7:0] div_r;
	logic [15:0] ena_r;
	logic [15:0] seen_r;
	logic raw_q;
	logic [1:0] rise_r;
	assign clr = (wr && reg_addr_i == PCP_INT_CLR_OFS) ?
		reg_wdata_i[15:0] : 16'h0;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctrl_r <= PCP_CTRL_RST;
			div_r <= PCP_CLKDIV_RST;
			ena_r <= PCP_INT_ENA_RST;
			{seen_r, raw_q, bck_q, ws_q, rise_r} <= '0;
		end else begin
			if (ctl_wr) ctrl_r <= reg_wdata_i[9:0];
			if (wr && reg_addr_i == PCP_CLKDIV_OFS) div_r <= reg_wdata_i[7:0];
			if (wr && reg_addr_i == PCP_INT_ENA_OFS) ena_r <= reg_wdata_i[15:0];
			seen_r <= (raw_q ? reg_rdata_o[15:0] : seen_r) & ~clr;
			raw_q <= rd && reg_addr_i == PCP_INT_RAW_OFS;
			bck_q <= bit_clock_o;
			ws_q <= word_select_o;
			// a control write restarts the count: mode change may reset ws
			if (ws_chg || ctl_wr) rise_r <= 2'h0;
			else if (rose && rise_r != 2'h3) rise_r <= rise_r + 2'h1;
		end
	end
	AST_RESET_OUT: assert property ($rose(rst_n_i) |-> !bit_clock_o
		&& !word_select_o && lcd_data_o == 24'h0 && reg_rdata_o == 32'h0)
		else $error("outputs not zero after reset");
	AST_RD_IDLE: assert property (ce_i && !reg_rd_i |=> reg_rdata_o == 32'h0)
		else $error("read data outside read cycle");
	AST_UNMAPPED: assert property (rd && reg_addr_i > PCP_STATE_OFS
		|=> reg_rdata_o == 32'h0) else $error("unmapped read not zero");
	AST_CTRL_RB: assert property (rd && reg_addr_i == PCP_CTRL_OFS
		|=> reg_rdata_o == {22'h0, ctrl_r}) else $error("control readback");
	AST_DIV_RB: assert property (rd && reg_addr_i == PCP_CLKDIV_OFS
		|=> reg_rdata_o == {24'h0, div_r}) else $error("divider readback");
	AST_ENA_RB: assert property (rd && reg_addr_i == PCP_INT_ENA_OFS
		|=> reg_rdata_o == {16'h0, ena_r}) else $error("enable readback");
	AST_ST_MASK: assert property (rd && reg_addr_i == PCP_INT_ST_OFS
		|=> (reg_rdata_o & ~{16'h0, ena_r}) == 32'h0)
		else $error("masked status shows disabled bit");
	AST_RAW_STICKY: assert property (raw_q |->
		(reg_rdata_o[15:0] & seen_r) == seen_r) else $error("raw bit lost");
	AST_WS_HALF: assert property (ws_chg && ctrl_r[PCP_B_TX_START]
		&& ctrl_r == $past(ctrl_r, 2) |-> rise_r + 2'(rose) == 2'h1)
		else $error("ws edge without exactly one bck rise");
	COV_WS: cover property (ws_chg && ctrl_r[PCP_B_TX_START]);
	COV_DMA: cover property (raw_q && reg_rdata_o[PCP_I_DMA]);
	COV_RX: cover property (rd && reg_addr_i == PCP_RXDATA_OFS);
endmodule : pcp_port_sva
bind pcp_port pcp_port_sva #(.DEPTH(DEPTH), .STALL_CYCLES(STALL_CYCLES))
	u_sva (.clk_sys_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wdata_i,
	.reg_wr_i, .reg_rd_i, .reg_rdata_o, .bit_clock_o, .word_select_o,
	.lcd_data_o);

// [pcp_cam_model.sv]
// camera module and converter clock on the far side of the port
// assumes the bench calls send; ns time units
`timescale 1ns/1ps
module pcp_cam_model (
	// converter clock control
	input wire logic run_pll_i,
	// camera pins
	output logic pclk_o,
	output logic line_sync_o,
	output logic frame_sync_o,
	output logic line_valid_o,
	output logic [15:0] data_o,
	// converter clock
	output logic pll_o
);
	initial begin
		{pclk_o, line_sync_o, frame_sync_o, line_valid_o, pll_o} = 5'h00;
		data_o = 16'hFFFF;
	end
	always #20 if (run_pll_i) pll_o = ~pll_o;
	// qualifiers high through the line, one dropped on demand
	task automatic send(input int n, input logic [15:0] base,
		input int drop, input int which);
		for (int i = 0; i < n; i++) begin
			line_sync_o = !(i == drop && which == 0);
			frame_sync_o = !(i == drop && which == 1);
			line_valid_o = !(i == drop && which == 2);
			data_o = base + 16'(i);
			#62.5 pclk_o = 1'b1;
			#62.5 pclk_o = 1'b0;
		end
		{line_sync_o, frame_sync_o, line_valid_o} = 3'h0;
		// released bus: drive the inverse, not the last value
		data_o = ~data_o;
	endtask : send
endmodule : pcp_cam_model

// [tb_pcp_port.sv]
// self-checking bench for the parallel lcd / camera / converter port
// assumes the camera model and the checker bind
`timescale 1ns/1ps
module tb_pcp_port;
	import pcp_pkg::*;
	localparam logic [31:0] PME = 32'h1 << PCP_B_PME;
	localparam logic [31:0] TXS = 32'h1 << PCP_B_TX_START;
	localparam logic [31:0] RXS = 32'h1 << PCP_B_RX_START;
	localparam logic [31:0] SX2 = 32'h1 << PCP_B_STRB_X2;
	localparam logic [31:0] CNV = 32'h1 << PCP_B_CONV;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic adc_valid_i = 1'b0;
	logic [7:0] adc_data_i = 8'h00;
	logic [7:0] dma_evt_i = 8'h00;
	logic run_pll = 1'b1;
	wire logic [31:0] reg_rdata_o;
	wire logic bit_clock_o, word_select_o, pclk, lsync, fsync, lvalid, pll;
	wire logic [23:0] lcd_data_o;
	wire logic [7:0] dac1_o, dac2_o;
	wire logic [15:0] cdata;
	int failures = 0;
	int checked = 0;
	always #2.5 clk_sys_i = ~clk_sys_i;
	pcp_cam_model cam (.run_pll_i(run_pll), .pclk_o(pclk),
		.line_sync_o(lsync), .frame_sync_o(fsync), .line_valid_o(lvalid),
		.data_o(cdata), .pll_o(pll));
	pcp_port #(.STALL_CYCLES(16)) DUT (.clk_sys_i, .rst_n_i, .ce_i(1'b1),
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.word_select_input_i(pclk), .line_sync_in_i(lsync),
		.frame_sync_in_i(fsync), .line_valid_in_i(lvalid),
		.capture_data_in_i(cdata), .halved_pll_clock_i(pll), .adc_valid_i,
		.adc_data_i, .dma_evt_i, .bit_clock_o, .word_select_o, .lcd_data_o,
		.dac1_o, .dac2_o);
	task automatic check(string what, logic [31:0] got, logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys_i);
		{reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rdc(string what, logic [7:0] a, logic [31:0] m,
		logic [31:0] exp);
		@(posedge clk_sys_i);
		{reg_addr_i, reg_rd_i} <= {a, 1'b1};
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1 check(what, reg_rdata_o & m, exp);
	endtask : rdc
	// bounded wait; a timeout shows up as a mismatch
	task automatic wait_out(string what, logic [31:0] exp, bit dac);
		int n;
		n = 0;
		#1;
		while (n < 900 && (dac ? {dac2_o, dac1_o} : lcd_data_o) !== exp) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		check(what, dac ? {dac2_o, dac1_o} : lcd_data_o, exp);
	endtask : wait_out
	task automatic pulse(logic [7:0] e);
		@(posedge clk_sys_i);
		dma_evt_i <= e;
		@(posedge clk_sys_i);
		dma_evt_i <= 8'h00;
	endtask : pulse
	task automatic test_regs();
		rdc("ctrl", PCP_CTRL_OFS, '1, 32'h0);
		rdc("layout", PCP_LAYOUT_OFS, '1, 32'h0);
		rdc("clkdiv", PCP_CLKDIV_OFS, '1, 32'h3);
		rdc("unmapped", 8'h40, '1, 32'h0);
		rdc("raw", PCP_INT_RAW_OFS, 32'hFF, 32'h54);
		for (int i = 0; i < 9; i++) wr(PCP_TXDATA_OFS, 32'h11223300 | i);
		rdc("raw full", PCP_INT_RAW_OFS, 32'hFF, 32'h5C);
		wr(PCP_INT_CLR_OFS, 32'hFFFF);
		rdc("raw clr", PCP_INT_RAW_OFS, 32'hFF, 32'h18);
		$display("test_regs done");
	endtask : test_regs
	task automatic test_lcd();
		logic [15:0] lay [3] = '{16'h0010, 16'h0012, 16'h0011};
		logic [31:0] exp [3] = '{32'hA1C3D4, 32'hC3D400, 32'hA1B200};
		wr(PCP_CTRL_OFS, PME | TXS | SX2);
		for (int i = 0; i < 8; i++) wait_out("lcd", 32'h223300 | i, 0);
		repeat (100) @(posedge clk_sys_i);
		check("lcd held", lcd_data_o, 32'h223307);
		rdc("tx stall", PCP_INT_RAW_OFS, 32'h1, 32'h1);
		wr(PCP_CTRL_OFS, PME | TXS | SX2 | (32'h1 << PCP_B_DATA_X2));
		for (int j = 0; j < 3; j++) begin
			wr(PCP_LAYOUT_OFS, 32'(lay[j]));
			wr(PCP_TXDATA_OFS, 32'hA1B2C3D4);
			wait_out("lcd layout", exp[j], 0);
		end
		$display("test_lcd done");
	endtask : test_lcd
	task automatic test_dac();
		wr(PCP_CTRL_OFS, PME | CNV | TXS);
		wr(PCP_TXDATA_OFS, 32'h3C005A00);
		wait_out("dac", 32'h3C5A, 1);
		@(posedge clk_sys_i);
		run_pll <= 1'b0;
		wr(PCP_TXDATA_OFS, 32'h11002200);
		repeat (400) @(posedge clk_sys_i);
		check("dac no clock", {dac2_o, dac1_o}, 32'h3C5A);
		run_pll <= 1'b1;
		wait_out("dac", 32'h1122, 1);
		$display("test_dac done");
	endtask : test_dac
	task automatic test_adc();
		wr(PCP_CTRL_OFS, 32'h0);
		wr(PCP_LAYOUT_OFS, 32'h1000);
		wr(PCP_CTRL_OFS, 32'h1 << PCP_B_ADC_ROUTE);
		wr(PCP_CTRL_OFS, PME | CNV | (32'h1 << PCP_B_ADC_ROUTE));
		wr(PCP_CTRL_OFS, PME | CNV | RXS | (32'h1 << PCP_B_ADC_ROUTE));
		@(posedge clk_sys_i);
		{adc_valid_i, adc_data_i} <= {1'b1, 8'h7E};
		@(posedge clk_sys_i);
		adc_valid_i <= 1'b0;
		rdc("adc", PCP_RXDATA_OFS, '1, 32'h7E00);
		rdc("rx empty", PCP_RXDATA_OFS, '1, 32'h0);
		$display("test_adc done");
	endtask : test_adc
	task automatic test_cam();
		wr(PCP_CTRL_OFS, 32'h0);
		wr(PCP_LAYOUT_OFS, 32'h1100);
		wr(PCP_CTRL_OFS, PME | RXS | 32'h1 << PCP_B_CAP_EN | 32'h1 << PCP_B_RX_FOL);
		for (int w = 0; w < 3; w++) cam.send(3, 16'hBEE0 + 16'(w * 4), 1, w);
		repeat (8) @(posedge clk_sys_i);
		rdc("state", PCP_STATE_OFS, 32'hFF00F, 32'h96000);
		for (int w = 0; w < 3; w++) begin
			rdc("cam", PCP_RXDATA_OFS, '1, 32'hBEE0 + 32'(w * 4));
			rdc("cam", PCP_RXDATA_OFS, '1, 32'hBEE2 + 32'(w * 4));
		end
		$display("test_cam done");
	endtask : test_cam
	task automatic test_irq();
		wr(PCP_INT_CLR_OFS, 32'hFFFF);
		repeat (40) @(posedge clk_sys_i);
		rdc("rx stall", PCP_INT_RAW_OFS, 32'h2, 32'h2);
		wr(PCP_INT_ENA_OFS, 32'hFF00);
		for (int k = 0; k < 8; k++) begin
			pulse(8'h1 << k);
			rdc("dma raw", PCP_INT_RAW_OFS, 32'hFF00, 32'h100 << k);
			rdc("dma st", PCP_INT_ST_OFS, 32'hFF00, 32'h100 << k);
			wr(PCP_INT_CLR_OFS, 32'h100 << k);
			rdc("dma clr", PCP_INT_RAW_OFS, 32'hFF00, 32'h0);
		end
		wr(PCP_INT_ENA_OFS, 32'h0);
		pulse(8'h01);
		rdc("masked", PCP_INT_ST_OFS, 32'hFF00, 32'h0);
		$display("test_irq done");
	endtask : test_irq
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	initial begin
		#400us;
		failures++;
		finish_test();
	end
	initial begin
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		test_regs();
		test_lcd();
		test_dac();
		test_adc();
		test_cam();
		test_irq();
		finish_test();
	end
endmodule : tb_pcp_port
